// ### rtl/ops_switch_ctrl.v
// Optical path protection switch controller: selection, revert, alarms.
// Assumes cfg_* and measurement inputs are synchronous to clk; the switch
// position sense and supply-fail flag come from pins and are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "ops_defs.vh"

module ops_switch_ctrl #(
    parameter integer SEC_CYCLES  = `OPS_SEC_CYCLES,
    parameter integer MOVE_TMO    = `OPS_MOVE_TMO_CYC,
    parameter integer TEMP_W      = 12
) (
    input  wire                        clk,
    input  wire                        sys_rst,
    input  wire                        cfg_we,
    input  wire                        cfg_mode,
    input  wire signed [`OPS_PWR_W-1:0]   cfg_thr_a,
    input  wire signed [`OPS_PWR_W-1:0]   cfg_thr_b,
    input  wire signed [`OPS_PWR_W-1:0]   cfg_hys_amp,
    input  wire [`OPS_HTIME_W-1:0]     cfg_hys_time,
    input  wire                        cfg_revert,
    input  wire                        cfg_primary,
    input  wire                        cfg_normal_pos,
    input  wire                        cmd_move,
    input  wire                        cmd_path,
    input  wire                        meas_valid,
    input  wire signed [`OPS_PWR_W-1:0]   meas_pwr_a,
    input  wire signed [`OPS_PWR_W-1:0]   meas_pwr_b,
    input  wire signed [TEMP_W-1:0]    meas_mod_temp,
    input  wire signed [TEMP_W-1:0]    meas_sw_temp,
    input  wire                        sw_pos_in,
    input  wire                        rail_fail_in,
    output reg                         sw_drive,
    output reg                         pos_out,
    output reg signed [`OPS_PWR_W-1:0]    pwr_a_out,
    output reg signed [`OPS_PWR_W-1:0]    pwr_b_out,
    output reg signed [TEMP_W-1:0]     mod_temp_out,
    output reg signed [TEMP_W-1:0]     sw_temp_out,
    output reg                         mode_out,
    output reg                         revert_out,
    output reg                         primary_out,
    output reg                         normal_pos_out,
    output reg signed [`OPS_PWR_W-1:0]    thr_a_out,
    output reg signed [`OPS_PWR_W-1:0]    thr_b_out,
    output reg signed [`OPS_PWR_W-1:0]    hys_amp_out,
    output reg [`OPS_HTIME_W-1:0]      hys_time_out,
    output reg                         lol_a_ok,
    output reg                         lol_b_ok,
    output reg                         both_dark_ok,
    output reg                         no_switch_ok,
    output reg                         power_ok,
    output reg                         excess_ok
);

// ****************************************************
// Helpers
// ****************************************************
    // Clamp a power setting into its legal range
    function signed [`OPS_PWR_W-1:0] clamp;
        input signed [`OPS_PWR_W-1:0] v;
        input signed [`OPS_PWR_W-1:0] lo;
        input signed [`OPS_PWR_W-1:0] hi;
        begin
            if (v < lo) begin
                clamp = lo;
            end else if (v > hi) begin
                clamp = hi;
            end else begin
                clamp = v;
            end
        end
    endfunction

    // Pick the path A or path B copy of a power value
    function signed [`OPS_PWR_W-1:0] by_path;
        input                         sel;
        input signed [`OPS_PWR_W-1:0] a;
        input signed [`OPS_PWR_W-1:0] b;
        begin
            by_path = (sel == `OPS_PATH_A) ? a : b;
        end
    endfunction

    // Above thr+hys; one extra bit so the sum cannot wrap, and both
    // operands stay signed so a negative threshold compares correctly
    function above_restore;
        input signed [`OPS_PWR_W-1:0] p;
        input signed [`OPS_PWR_W-1:0] thr;
        input signed [`OPS_PWR_W-1:0] hys;
        reg signed [`OPS_PWR_W:0] p_w;
        reg signed [`OPS_PWR_W:0] lvl;
        begin
            p_w = {p[`OPS_PWR_W-1], p};
            lvl = {thr[`OPS_PWR_W-1], thr} + {hys[`OPS_PWR_W-1], hys};
            above_restore = (p_w > lvl);
        end
    endfunction

    // Loss-of-light with hysteresis: enter below thr, leave above thr+hys
    function lol_next;
        input                         lost;
        input signed [`OPS_PWR_W-1:0] p;
        input signed [`OPS_PWR_W-1:0] thr;
        input signed [`OPS_PWR_W-1:0] hys;
        begin
            if (lost) begin
                lol_next = !above_restore(p, thr, hys);
            end else begin
                lol_next = (p < thr);
            end
        end
    endfunction

// ****************************************************
// Pin synchronisers
// ****************************************************
    // Both pins are asynchronous; only the second stage feeds logic
    reg [1:0] pos_sync_q;
    reg [1:0] rail_sync_q;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_sync_q  <= 2'h0;
            rail_sync_q <= 2'h0;
        end else begin
            pos_sync_q  <= {pos_sync_q[0], sw_pos_in};
            rail_sync_q <= {rail_sync_q[0], rail_fail_in};
        end
    end

    wire pos_s  = pos_sync_q[1];
    wire rail_s = rail_sync_q[1];

// ****************************************************
// Configuration
// ****************************************************
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_out       <= `OPS_MODE_AUTO;
            revert_out     <= 1'b1;
            primary_out    <= `OPS_PATH_A;
            normal_pos_out <= `OPS_PATH_A;
            thr_a_out      <= `OPS_THR_RST;
            thr_b_out      <= `OPS_THR_RST;
            hys_amp_out    <= `OPS_HYS_RST;
            hys_time_out   <= `OPS_HTIME_RST;
        end else if (cfg_we) begin
            mode_out       <= cfg_mode;
            revert_out     <= cfg_revert;
            primary_out    <= cfg_primary;
            normal_pos_out <= cfg_normal_pos;
            thr_a_out      <= clamp(cfg_thr_a, `OPS_THR_MIN, `OPS_THR_MAX);
            thr_b_out      <= clamp(cfg_thr_b, `OPS_THR_MIN, `OPS_THR_MAX);
            hys_amp_out    <= clamp(cfg_hys_amp, `OPS_HYS_MIN, `OPS_HYS_MAX);
            hys_time_out   <= (cfg_hys_time > `OPS_HTIME_MAX) ? `OPS_HTIME_MAX
                                                              : cfg_hys_time;
        end
    end

// ****************************************************
// Light status
// ****************************************************
    reg lost_a_q;
    reg lost_b_q;

    wire lost_a_d = lol_next(lost_a_q, pwr_a_out, thr_a_out, hys_amp_out);
    wire lost_b_d = lol_next(lost_b_q, pwr_b_out, thr_b_out, hys_amp_out);

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_a_out    <= {`OPS_PWR_W{1'b0}};
            pwr_b_out    <= {`OPS_PWR_W{1'b0}};
            mod_temp_out <= {TEMP_W{1'b0}};
            sw_temp_out  <= {TEMP_W{1'b0}};
            lost_a_q     <= 1'b0;
            lost_b_q     <= 1'b0;
        end else begin
            if (meas_valid) begin
                pwr_a_out    <= meas_pwr_a;
                pwr_b_out    <= meas_pwr_b;
                mod_temp_out <= meas_mod_temp;
                sw_temp_out  <= meas_sw_temp;
            end
            lost_a_q <= lost_a_d;
            lost_b_q <= lost_b_d;
        end
    end

    wire pri_lost = (primary_out == `OPS_PATH_A) ? lost_a_q : lost_b_q;
    wire sec_lost = (primary_out == `OPS_PATH_A) ? lost_b_q : lost_a_q;
    wire signed [`OPS_PWR_W-1:0] pri_pwr = by_path(primary_out, pwr_a_out, pwr_b_out);
    wire signed [`OPS_PWR_W-1:0] pri_thr = by_path(primary_out, thr_a_out, thr_b_out);
    wire pri_restored = above_restore(pri_pwr, pri_thr, hys_amp_out);
    // Instant dip below threshold, used for fast fail-over
    wire pri_below = (pri_pwr < pri_thr);

// ****************************************************
// Revert timer
// ****************************************************
    reg [31:0]               tick_cnt_q;
    reg [`OPS_HTIME_W-1:0]   sec_cnt_q;
    wire secondary_sel = (sw_drive != primary_out);
    wire timing = (mode_out == `OPS_MODE_AUTO) && revert_out && secondary_sel
                  && pri_restored;
    wire tick = (tick_cnt_q == SEC_CYCLES - 1);
    wire revert_due = timing && (sec_cnt_q >= hys_time_out);

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_q <= 32'h0;
            sec_cnt_q  <= {`OPS_HTIME_W{1'b0}};
        end else if (!timing) begin
            tick_cnt_q <= 32'h0;
            sec_cnt_q  <= {`OPS_HTIME_W{1'b0}};
        end else if (tick) begin
            tick_cnt_q <= 32'h0;
            if (sec_cnt_q != `OPS_HTIME_MAX) begin
                sec_cnt_q <= sec_cnt_q + 1'b1;
            end
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

// ****************************************************
// Path selection
// ****************************************************
    reg sw_drive_d;

    always @* begin
        sw_drive_d = sw_drive;
        if (mode_out == `OPS_MODE_MANUAL) begin
            if (cmd_move) begin
                sw_drive_d = cmd_path;
            end
        end else if (!secondary_sel) begin
            if (pri_below && !sec_lost) begin
                sw_drive_d = ~primary_out;
            end
        end else if (sec_lost && (pri_lost || !pri_below)) begin
            sw_drive_d = primary_out;
        end else if (revert_due) begin
            sw_drive_d = primary_out;
        end
    end

// ****************************************************
// Switch move supervision and alarms
// ****************************************************
    reg [31:0] move_cnt_q;
    reg        moving_q;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_drive     <= `OPS_PATH_A;
            pos_out      <= `OPS_PATH_A;
            moving_q     <= 1'b0;
            move_cnt_q   <= 32'h0;
            lol_a_ok     <= `OPS_OK;
            lol_b_ok     <= `OPS_OK;
            both_dark_ok <= `OPS_OK;
            no_switch_ok <= `OPS_OK;
            power_ok     <= `OPS_OK;
            excess_ok    <= `OPS_OK;
        end else begin
            sw_drive <= sw_drive_d;
            pos_out  <= pos_s;
            // time the move
            // A new command restarts the timeout; the old target is dropped
            if (sw_drive_d != sw_drive) begin
                moving_q   <= 1'b1;
                move_cnt_q <= 32'h0;
            end else if (moving_q) begin
                if (pos_s == sw_drive) begin
                    moving_q     <= 1'b0;
                    no_switch_ok <= `OPS_OK;
                end else if (move_cnt_q == MOVE_TMO - 1) begin
                    moving_q     <= 1'b0;
                    no_switch_ok <= `OPS_ALARM;
                end else begin
                    move_cnt_q <= move_cnt_q + 32'h1;
                end
            end
            lol_a_ok     <= ~lost_a_d;
            lol_b_ok     <= ~lost_b_d;
            both_dark_ok <= ~(lost_a_d & lost_b_d);
            power_ok     <= ~rail_s;
            excess_ok    <= ~((pwr_a_out >= `OPS_EXCESS_PWR)
                             | (pwr_b_out >= `OPS_EXCESS_PWR));
        end
    end

endmodule // ops_switch_ctrl
`default_nettype wire

// ### rtl/ops_defs.vh
// Constants for the optical path protection switch controller.
// Assumes a 10 MHz system clock; powers in signed 0.1 dB units.
`ifndef OPS_DEFS_VH
`define OPS_DEFS_VH

// ****************************************************
// Encodings
// ****************************************************
`define OPS_MODE_AUTO      1'b0
`define OPS_MODE_MANUAL    1'b1
`define OPS_PATH_A         1'b0
`define OPS_PATH_B         1'b1
`define OPS_ALARM          1'b0
`define OPS_OK             1'b1

// ****************************************************
// Limits and reset values, 0.1 dB units; hold times in seconds
// ****************************************************
`define OPS_PWR_W          12
`define OPS_THR_MIN        12'shF9C
`define OPS_THR_MAX        12'sh08C
`define OPS_THR_RST        12'sh032
`define OPS_HYS_MIN        12'sh005
`define OPS_HYS_MAX        12'sh05F
`define OPS_HYS_RST        12'sh00A
`define OPS_EXCESS_PWR     12'sh0F0
`define OPS_HTIME_W        10
`define OPS_HTIME_MAX      10'h258
`define OPS_HTIME_RST      10'h03C

// ****************************************************
// Timing
// ****************************************************
`define OPS_CLK_HZ         10000000
`define OPS_SEC_CYCLES     (`OPS_CLK_HZ / 1)
`define OPS_MOVE_TMO_MS    50
`define OPS_MOVE_TMO_CYC   ((`OPS_CLK_HZ / 1000) * `OPS_MOVE_TMO_MS)

`endif

// ### bench/ops_lcu_model.sv
// Local control unit model: loads configuration and issues moves.
// Assumes the controller takes cfg_we and cmd_move on a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module ops_lcu_model (
    input  wire logic              clk,
    output var  logic              cfg_we,
    output var  logic              cfg_mode,
    output var  logic signed [11:0] cfg_thr_a,
    output var  logic signed [11:0] cfg_thr_b,
    output var  logic signed [11:0] cfg_hys_amp,
    output var  logic [9:0]        cfg_hys_time,
    output var  logic              cfg_revert,
    output var  logic              cfg_primary,
    output var  logic              cfg_normal_pos,
    output var  logic              cmd_move,
    output var  logic              cmd_path
);
    // ****************************************
    // Tasks
    // ****************************************
    initial begin
        {cfg_we, cfg_mode, cfg_revert, cfg_primary, cfg_normal_pos} = 5'h00;
        {cfg_thr_a, cfg_thr_b, cfg_hys_amp, cfg_hys_time} = 46'h0;
        {cmd_move, cmd_path} = 2'h0;
    end
    task automatic move(input logic p);
        @(posedge clk) #1;
        cmd_path = p;
        cmd_move = 1'b1;
        @(posedge clk) #1 cmd_move = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // All fields go together, so one strobe carries a whole setting
    task automatic cfg(input logic m, input logic signed [11:0] ta, tb, hy,
                       input logic [9:0] ht, input logic rv, pr, np);
        @(posedge clk) #1;
        {cfg_mode, cfg_thr_a, cfg_thr_b, cfg_hys_amp} = {m, ta, tb, hy};
        {cfg_hys_time, cfg_revert, cfg_primary, cfg_normal_pos} = {ht, rv, pr, np};
        cfg_we = 1'b1;
        @(posedge clk) #1 cfg_we = 1'b0;
        @(posedge clk) #1;
    endtask
endmodule // ops_lcu_model
`default_nettype wire

// ### bench/ops_sc_assertions.sv
// Port-level checks for the switch controller.
// Bound to ops_switch_ctrl; one clock, reset active high.
`timescale 1ns/1ps
`default_nettype none
module ops_sc_assertions (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               cfg_we,
    input wire logic               cfg_mode,
    input wire logic               cfg_revert,
    input wire logic               cmd_move,
    input wire logic               cmd_path,
    input wire logic               meas_valid,
    input wire logic signed [11:0] meas_pwr_a,
    input wire logic signed [11:0] meas_pwr_b,
    input wire logic               rail_fail_in,
    input wire logic               sw_drive,
    input wire logic               pos_out,
    input wire logic signed [11:0] pwr_a_out,
    input wire logic signed [11:0] pwr_b_out,
    input wire logic               mode_out,
    input wire logic               revert_out,
    input wire logic               primary_out,
    input wire logic signed [11:0] thr_a_out,
    input wire logic signed [11:0] thr_b_out,
    input wire logic               lol_a_ok,
    input wire logic               lol_b_ok,
    input wire logic               both_dark_ok,
    input wire logic               no_switch_ok,
    input wire logic               power_ok,
    input wire logic               excess_ok
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_cfg_readback:
        assert property (cfg_we |=> {mode_out, revert_out} == $past({cfg_mode, cfg_revert}))
        else $error("config readback wrong");
    a_pwr_latch:
        assert property (meas_valid |=> pwr_a_out == $past(meas_pwr_a) && pwr_b_out == $past(meas_pwr_b))
        else $error("power readback wrong");
    a_excess_level:
        assert property (meas_valid |-> ##2 excess_ok ==
            !($past(meas_pwr_a, 2) >= 12'sh0F0 || $past(meas_pwr_b, 2) >= 12'sh0F0))
        else $error("excess power flag wrong");
    a_both_dark_flag:
        assert property (both_dark_ok == (lol_a_ok || lol_b_ok))
        else $error("both dark flag wrong");
    a_power_delay:
        assert property (power_ok == !$past(rail_fail_in, 3))
        else $error("power status wrong");
    a_manual_cmd:
        assert property (cmd_move && mode_out |=> sw_drive == $past(cmd_path))
        else $error("manual move not taken");
    a_manual_hold:
        assert property (mode_out && !cmd_move && !cfg_we |=> $stable(sw_drive))
        else $error("manual mode moved alone");
    a_primary_keep:
        assert property (!mode_out && !cfg_we && sw_drive == primary_out &&
            (primary_out ? pwr_b_out >= thr_b_out : pwr_a_out >= thr_a_out)
            |=> sw_drive == primary_out)
        else $error("left a lit primary");
    a_no_switch_cause:
        assert property ($fell(no_switch_ok) |-> $past(sw_drive) != $past(pos_out))
        else $error("no switch alarm without cause");
endmodule // ops_sc_assertions
`default_nettype wire

// ### bench/ops_switch_ctrl_tb_top.sv
// Self-checking bench for the switch controller with an LCU model.
// Models the switch sense as following the drive unless held stuck.
`timescale 1ns/1ps
`default_nettype none
`include "ops_defs.vh"
module ops_switch_ctrl_tb_top;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk = 0, sys_rst = 1, meas_valid = 0, stuck = 0, rail_fail_in = 0, pos_q = 0;
    logic cfg_we, cfg_mode, cfg_revert, cfg_primary, cfg_normal_pos, cmd_move, cmd_path;
    logic sw_drive, pos_out, mode_out, revert_out, primary_out, normal_pos_out;
    logic lol_a_ok, lol_b_ok, both_dark_ok, no_switch_ok, power_ok, excess_ok;
    logic signed [11:0] cfg_thr_a, cfg_thr_b, cfg_hys_amp, meas_pwr_a = 0, meas_pwr_b = 0;
    logic signed [11:0] meas_mod_temp = 0, meas_sw_temp = 0;
    logic signed [11:0] pwr_a_out, pwr_b_out, mod_temp_out, sw_temp_out;
    logic signed [11:0] thr_a_out, thr_b_out, hys_amp_out;
    logic [9:0]         cfg_hys_time, hys_time_out;
    int                 n_fail = 0, comparisons = 0;
    always #50 clk = ~clk;
    // Stuck sense lets the move timeout be seen
    always @(posedge clk) pos_q <= stuck ? pos_q : sw_drive;
    // Short second and timeout keep the revert and move checks fast
    ops_switch_ctrl #(.SEC_CYCLES(10), .MOVE_TMO(20)) i_dut (.sw_pos_in(pos_q), .*);
    ops_lcu_model i_lcu (.*);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic meas(input logic signed [11:0] a, b);
        @(posedge clk) #1;
        {meas_pwr_a, meas_pwr_b} = {a, b};
        // Temperatures cross over the powers so a swapped latch shows
        {meas_mod_temp, meas_sw_temp} = {b, a};
        meas_valid = 1'b1;
        @(posedge clk) #1 meas_valid = 1'b0;
        cyc(4);
    endtask
    task automatic stop_test;
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #200000;
        n_fail++;
        stop_test;
    end
    initial begin
        cyc(16);
        sys_rst = 0;
        chk({mode_out, revert_out, primary_out, normal_pos_out}, 4'h4);
        chk({thr_a_out, hys_amp_out}, {`OPS_THR_RST, `OPS_HYS_RST});
        chk(hys_time_out, `OPS_HTIME_RST);
        chk({sw_drive, lol_a_ok, lol_b_ok, both_dark_ok, no_switch_ok}, 5'h0F);
        i_lcu.cfg(0, -200, 300, 1, 700, 1, 0, 1);
        chk({thr_a_out, thr_b_out}, {`OPS_THR_MIN, `OPS_THR_MAX});
        chk({hys_amp_out, hys_time_out}, {`OPS_HYS_MIN, `OPS_HTIME_MAX});
        chk({primary_out, normal_pos_out}, 2'h1);
        i_lcu.cfg(0, 50, 50, 10, 2, 1, 0, 0);
        meas(70, 65);
        chk({pwr_a_out, pwr_b_out, mod_temp_out, sw_temp_out}, 48'h046041041046);
        chk({sw_drive, pos_out, lol_a_ok}, 3'h1);
        meas(40, 60);
        chk({sw_drive, lol_a_ok, both_dark_ok}, 3'h5);
        meas(55, 60);
        chk({sw_drive, lol_a_ok}, 2'h2);
        meas(70, 60);
        cyc(10);
        meas(55, 60);
        meas(70, 60);
        cyc(8);
        chk(sw_drive, 1'b1);
        cyc(14);
        chk({sw_drive, lol_a_ok}, 2'h1);
        meas(40, 60);
        meas(40, 40);
        chk({sw_drive, lol_b_ok, both_dark_ok}, 3'h0);
        i_lcu.cfg(0, 50, 50, 10, 0, 1, 1, 0);
        meas(40, 80);
        chk({sw_drive, primary_out, normal_pos_out}, 3'h6);
        i_lcu.cfg(0, 50, 50, 10, 0, 0, 0, 0);
        meas(80, 80);
        cyc(3);
        chk({sw_drive, lol_a_ok}, 2'h3);
        meas(240, 80);
        chk(excess_ok, `OPS_ALARM);
        meas(239, 40);
        chk(excess_ok, `OPS_OK);
        chk({sw_drive, lol_b_ok}, 2'h0);
        i_lcu.cfg(1, 50, 50, 10, 0, 0, 0, 0);
        chk(mode_out, `OPS_MODE_MANUAL);
        i_lcu.move(0);
        meas(10, 80);
        chk(sw_drive, `OPS_PATH_A);
        i_lcu.move(1);
        chk(sw_drive, `OPS_PATH_B);
        stuck = 1;
        i_lcu.move(0);
        cyc(26);
        chk(no_switch_ok, `OPS_ALARM);
        stuck = 0;
        i_lcu.move(1);
        cyc(6);
        chk({sw_drive, no_switch_ok}, 2'h3);
        i_lcu.cfg(0, 50, 50, 10, 0, 1, 0, 0);
        i_lcu.move(0);
        chk(sw_drive, `OPS_PATH_B);
        rail_fail_in = 1;
        cyc(5);
        chk(power_ok, `OPS_ALARM);
        rail_fail_in = 0;
        cyc(5);
        chk(power_ok, `OPS_OK);
        stop_test;
    end
endmodule // ops_switch_ctrl_tb_top
bind ops_switch_ctrl ops_sc_assertions i_chk (.*);
`default_nettype wire
